//--- include/lane_map_pkg.sv
// Shared constants, format codes and helpers for the real-output lane mapper.
package lane_map_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int SAMPLE_W = 16;
   localparam int OCTET_W = 8;
   localparam int LANES_PER_CHAN = 4;
   localparam int CHANS = 2;
   localparam int SEL_A_W = 2;
   localparam int DECIM_W = 6;

   // ----------------------------------------------------------------
   // Complex decimation factors offered in this mode
   // ----------------------------------------------------------------
   localparam logic [DECIM_W-1:0] DECIM_8 = 6'h08;
   localparam logic [DECIM_W-1:0] DECIM_9 = 6'h09;
   localparam logic [DECIM_W-1:0] DECIM_10 = 6'h0a;
   localparam logic [DECIM_W-1:0] DECIM_12 = 6'h0c;
   localparam logic [DECIM_W-1:0] DECIM_16 = 6'h10;
   localparam logic [DECIM_W-1:0] DECIM_18 = 6'h12;
   localparam logic [DECIM_W-1:0] DECIM_20 = 6'h14;
   localparam logic [DECIM_W-1:0] DECIM_24 = 6'h18;
   localparam logic [DECIM_W-1:0] DECIM_32 = 6'h20;
   localparam logic [DECIM_W-1:0] DECIM_RESET = DECIM_8;
   localparam logic [1:0] DDC_PER_CHAN = 2'h1;

   // ----------------------------------------------------------------
   // PLL multipliers and format selects
   // ----------------------------------------------------------------
   localparam logic [5:0] PLL_20X = 6'h14;
   localparam logic [5:0] PLL_40X = 6'h28;
   localparam logic [SEL_A_W-1:0] SEL_A_4211 = 2'h1;
   localparam logic SEL_B_4211 = 1'b1;
   localparam logic SEL_C_4211 = 1'b0;
   localparam logic [SEL_A_W-1:0] SEL_A_4222 = 2'h1;
   localparam logic SEL_B_4222 = 1'b0;
   localparam logic SEL_C_4222 = 1'b0;
   localparam logic [SEL_A_W-1:0] SEL_A_2221 = 2'h0;
   localparam logic SEL_B_2221 = 1'b0;
   localparam logic SEL_C_2221 = 1'b1;
   localparam logic [SEL_A_W-1:0] SEL_A_2242 = 2'h2;
   localparam logic SEL_B_2242 = 1'b0;
   localparam logic SEL_C_2242 = 1'b0;

   typedef enum logic [2:0] {FMT_NONE, FMT_4211, FMT_4222, FMT_2221, FMT_2242} fmt_t;

   function automatic fmt_t decodeFmt(input logic [SEL_A_W-1:0] a, input logic b, input logic c);
      fmt_t f;
      f = FMT_NONE;
      if (a == SEL_A_4211 && b == SEL_B_4211 && c == SEL_C_4211) f = FMT_4211;
      else if (a == SEL_A_4222 && b == SEL_B_4222 && c == SEL_C_4222) f = FMT_4222;
      else if (a == SEL_A_2221 && b == SEL_B_2221 && c == SEL_C_2221) f = FMT_2221;
      else if (a == SEL_A_2242 && b == SEL_B_2242 && c == SEL_C_2242) f = FMT_2242;
      return f;
   endfunction : decodeFmt

   // Index of the last octet in a frame, that is F minus one.
   function automatic logic [1:0] lastOctet(input fmt_t f);
      case (f)
         FMT_4211: return 2'h0;
         FMT_4222: return 2'h1;
         FMT_2221: return 2'h1;
         FMT_2242: return 2'h3;
         default: return 2'h0;
      endcase
   endfunction : lastOctet

   function automatic logic isFourLane(input fmt_t f);
      return (f == FMT_4211) || (f == FMT_4222);
   endfunction : isFourLane

   function automatic logic [5:0] pllOf(input fmt_t f);
      return isFourLane(f) ? PLL_20X : PLL_40X;
   endfunction : pllOf

   function automatic logic decimOk(input logic [DECIM_W-1:0] d, input fmt_t f);
      logic ok;
      ok = 1'b0;
      case (d)
         DECIM_8, DECIM_9, DECIM_10, DECIM_12, DECIM_16, DECIM_18, DECIM_20: ok = 1'b1;
         DECIM_24, DECIM_32: ok = !isFourLane(f);
         default: ok = 1'b0;
      endcase
      return ok && (f != FMT_NONE);
   endfunction : decimOk

endpackage : lane_map_pkg

//--- include/lane_link_if.sv
// Lane bundle and mode selects between the converter end and the receiver end.
`timescale 1ns/100ps
interface lane_link_if;
   import lane_map_pkg::*;
   logic [SEL_A_W-1:0] frameFormatSelectA;
   logic frameFormatSelectB;
   logic frameFormatSelectC;
   logic [DECIM_W-1:0] decimation;
   logic [LANES_PER_CHAN-1:0][OCTET_W-1:0] chanALane;
   logic [LANES_PER_CHAN-1:0][OCTET_W-1:0] chanBLane;
   logic [LANES_PER_CHAN-1:0] chanALaneValid;
   logic [LANES_PER_CHAN-1:0] chanBLaneValid;
   logic frameStart;
   logic [5:0] pllMult;
   logic configOk;

   modport converter (
      input frameFormatSelectA, frameFormatSelectB, frameFormatSelectC, decimation,
      output chanALane, chanBLane, chanALaneValid, chanBLaneValid, frameStart, pllMult, configOk
   );
   modport receiver (
      output frameFormatSelectA, frameFormatSelectB, frameFormatSelectC, decimation,
      input chanALane, chanBLane, chanALaneValid, chanBLaneValid, frameStart, pllMult, configOk
   );
endinterface : lane_link_if

//--- hw/lane_framer.sv
// Converter end: maps channel A and B samples onto the output lanes per frame format.
//
// Notes on behaviour
// - Complex decimation 8 to 32, one converter each.
// - Four-lane one-octet format uses 20X, selects 1,1,0.
// - Four-lane two-octet format uses 20X, selects 1,0,0.
// - Two-lane two-octet format uses 40X, selects 0,0,1.
// - Two-lane four-octet format uses 40X, selects 2,0,0.
// - Each channel stays on its own lanes.
// - One-octet format: lane0 high byte, lane1 low byte.
// - Two-octet four-lane: lane0 sample0, lane1 sample1.
// - Two-lane one-sample: only lane1, high then low.
// - Two-lane two-sample: lane1 sample0 then sample1.
// - No decimation 24 or 32 with four lanes.
`timescale 1ns/100ps
module lane_framer (
   input wire logic clk,
   input wire logic rst,
   lane_link_if.converter link,
   input wire logic sampleValid,
   output logic sampleReady,
   input wire logic [lane_map_pkg::SAMPLE_W-1:0] chanASample0,
   input wire logic [lane_map_pkg::SAMPLE_W-1:0] chanASample1,
   input wire logic [lane_map_pkg::SAMPLE_W-1:0] chanBSample0,
   input wire logic [lane_map_pkg::SAMPLE_W-1:0] chanBSample1,
   output logic [1:0] ddcPerChannel,
   output logic configRefused
);
   import lane_map_pkg::*;

   // ----------------------------------------------------------------
   // Format decode and acceptance
   // ----------------------------------------------------------------
   fmt_t selFmt;
   logic cfgOk;
   logic take;
   logic busy_r;
   logic busyNxt;
   logic [1:0] idx_r;
   logic [1:0] idxNxt;
   fmt_t fmt_r;
   fmt_t fmtNxt;
   logic [CHANS-1:0][1:0][SAMPLE_W-1:0] smp_r;
   logic [CHANS-1:0][1:0][SAMPLE_W-1:0] smpNxt;
   logic lastNow;

   assign selFmt = decodeFmt(link.frameFormatSelectA, link.frameFormatSelectB,
                             link.frameFormatSelectC);
   assign cfgOk = decimOk(link.decimation, selFmt);
   assign lastNow = busy_r && (idx_r == lastOctet(fmt_r));
   // A new frame may be taken on the last octet of the current one, so frames run back to back.
   assign sampleReady = cfgOk && (!busy_r || lastNow);
   assign take = sampleValid && sampleReady;

   // ----------------------------------------------------------------
   // Frame sequencing
   // ----------------------------------------------------------------
   // Format and samples are captured at the take, so a select change mid-frame only shapes the next frame.
   // The octet index runs from zero to the last octet of the captured format, then returns to zero and parks there.
   always_comb
   begin
      busyNxt = busy_r;
      idxNxt = idx_r;
      fmtNxt = fmt_r;
      smpNxt = smp_r;
      if (take)
      begin
         busyNxt = 1'b1;
         idxNxt = 2'h0;
         fmtNxt = selFmt;
         smpNxt = '{'{chanBSample1, chanBSample0}, '{chanASample1, chanASample0}};
      end
      else if (lastNow)
      begin
         busyNxt = 1'b0;
         idxNxt = 2'h0;
      end
      else if (busy_r)
      begin
         idxNxt = idx_r + 2'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busy_r <= 1'b0;
         idx_r <= 2'h0;
         fmt_r <= FMT_NONE;
         smp_r <= '0;
      end
      else
      begin
         busy_r <= busyNxt;
         idx_r <= idxNxt;
         fmt_r <= fmtNxt;
         smp_r <= smpNxt;
      end
   end

   // ----------------------------------------------------------------
   // Lane octet placement
   // ----------------------------------------------------------------
   // Returns {valid, octet} for one lane of one channel at one octet index.
   function automatic logic [OCTET_W:0] placeOctet(input fmt_t f, input int lane, input logic [1:0] idx,
                                                   input logic [SAMPLE_W-1:0] s0,
                                                   input logic [SAMPLE_W-1:0] s1);
      logic [OCTET_W:0] r;
      // Lanes outside the pattern are forced to zero so no stale octet reaches the receiver.
      r = '0;
      case (f)
         FMT_4211:
         begin
            if (lane == 0) r = {1'b1, s0[15:8]};
            else if (lane == 1) r = {1'b1, s0[7:0]};
         end
         FMT_4222:
         begin
            if (lane == 0) r = {1'b1, idx[0] ? s0[7:0] : s0[15:8]};
            else if (lane == 1) r = {1'b1, idx[0] ? s1[7:0] : s1[15:8]};
         end
         FMT_2221:
         begin
            if (lane == 1) r = {1'b1, idx[0] ? s0[7:0] : s0[15:8]};
         end
         FMT_2242:
         begin
            if (lane == 1)
            begin
               case (idx)
                  2'h0: r = {1'b1, s0[15:8]};
                  2'h1: r = {1'b1, s0[7:0]};
                  2'h2: r = {1'b1, s1[15:8]};
                  default: r = {1'b1, s1[7:0]};
               endcase
            end
         end
         default: r = '0;
      endcase
      return r;
   endfunction : placeOctet

   // ----------------------------------------------------------------
   // Lane registers
   // ----------------------------------------------------------------
   // Octets are placed from the next-state values so they leave flip-flops in step with the frame marker.
   logic [CHANS-1:0][LANES_PER_CHAN-1:0][OCTET_W-1:0] lane_r;
   logic [CHANS-1:0][LANES_PER_CHAN-1:0] laneValid_r;
   logic frameStart_r;

   // Both channels share one placement pattern; each channel only ever feeds its own lane group.
   for (genvar ch = 0; ch < CHANS; ch++)
   begin : g_chan
      for (genvar ln = 0; ln < LANES_PER_CHAN; ln++)
      begin : g_lane
         logic [OCTET_W:0] slot;
         logic [OCTET_W:0] slot_r;
         assign slot = busyNxt ? placeOctet(fmtNxt, ln, idxNxt, smpNxt[ch][0], smpNxt[ch][1]) : '0;
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               slot_r <= '0;
            end
            else
            begin
               slot_r <= slot;
            end
         end
         // Each lane keeps its own register, so every bit of the lane bus has a single driver.
         assign lane_r[ch][ln] = slot_r[OCTET_W-1:0];
         assign laneValid_r[ch][ln] = slot_r[OCTET_W];
      end
   end

   // ----------------------------------------------------------------
   // Frame marker
   // ----------------------------------------------------------------
   // The marker lines up with octet zero on the lanes, one cycle after the take.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         frameStart_r <= 1'b0;
      end
      else
      begin
         frameStart_r <= take;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign link.chanALane = lane_r[0];
   assign link.chanBLane = lane_r[1];
   assign link.chanALaneValid = laneValid_r[0];
   assign link.chanBLaneValid = laneValid_r[1];
   assign link.frameStart = frameStart_r;
   // Line rate over sample clock is this multiplier over the decimation, 2.5 or 5 at decimation 8.
   assign link.pllMult = pllOf(selFmt);
   assign link.configOk = cfgOk;
   assign ddcPerChannel = DDC_PER_CHAN;
   // Refused configurations simply hold off new frames; nothing already in flight is cut short.
   assign configRefused = !cfgOk;

endmodule : lane_framer

//--- hw/lane_deframer.sv
// Receiver end: drives the mode selects and rebuilds channel samples from the lanes.
`timescale 1ns/100ps
module lane_deframer (
   input wire logic clk,
   input wire logic rst,
   lane_link_if.receiver link,
   input wire logic cfgWrite,
   input wire logic [lane_map_pkg::SEL_A_W-1:0] cfgSelA,
   input wire logic cfgSelB,
   input wire logic cfgSelC,
   input wire logic [lane_map_pkg::DECIM_W-1:0] cfgDecimation,
   output logic cfgRejected,
   output logic sampleOutValid,
   output logic [1:0] samplesPerFrame,
   output logic [lane_map_pkg::SAMPLE_W-1:0] chanAOut0,
   output logic [lane_map_pkg::SAMPLE_W-1:0] chanAOut1,
   output logic [lane_map_pkg::SAMPLE_W-1:0] chanBOut0,
   output logic [lane_map_pkg::SAMPLE_W-1:0] chanBOut1
);
   import lane_map_pkg::*;

   // ----------------------------------------------------------------
   // Configuration held by the controlling end
   // ----------------------------------------------------------------
   logic [SEL_A_W-1:0] selA_r;
   logic selB_r;
   logic selC_r;
   logic [DECIM_W-1:0] decim_r;
   logic rejected_r;
   logic cfgLegal;
   fmt_t fmt;

   // An illegal pair never reaches the converter; the previous setting stays in force.
   assign cfgLegal = decimOk(cfgDecimation, decodeFmt(cfgSelA, cfgSelB, cfgSelC));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         selA_r <= SEL_A_4211;
         selB_r <= SEL_B_4211;
         selC_r <= SEL_C_4211;
         decim_r <= DECIM_RESET;
         rejected_r <= 1'b0;
      end
      else if (cfgWrite)
      begin
         rejected_r <= !cfgLegal;
         if (cfgLegal)
         begin
            selA_r <= cfgSelA;
            selB_r <= cfgSelB;
            selC_r <= cfgSelC;
            decim_r <= cfgDecimation;
         end
      end
   end

   assign link.frameFormatSelectA = selA_r;
   assign link.frameFormatSelectB = selB_r;
   assign link.frameFormatSelectC = selC_r;
   assign link.decimation = decim_r;
   assign cfgRejected = rejected_r;
   assign fmt = decodeFmt(selA_r, selB_r, selC_r);

   // ----------------------------------------------------------------
   // Sample reassembly
   // ----------------------------------------------------------------
   logic [1:0] idx_r;
   logic [1:0] idx;
   logic inFrame_r;
   logic done;
   logic [CHANS-1:0][LANES_PER_CHAN-1:0][OCTET_W-1:0] lanes;
   logic [CHANS-1:0][1:0][SAMPLE_W-1:0] smp_r;
   logic valid_r;

   assign lanes = {link.chanBLane, link.chanALane};
   assign idx = link.frameStart ? 2'h0 : idx_r + 2'h1;
   assign done = (link.frameStart || inFrame_r) && (idx == lastOctet(fmt));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         idx_r <= 2'h0;
         inFrame_r <= 1'b0;
         valid_r <= 1'b0;
      end
      else
      begin
         idx_r <= idx;
         inFrame_r <= (link.frameStart || inFrame_r) && !done;
         valid_r <= done;
      end
   end

   for (genvar ch = 0; ch < CHANS; ch++)
   begin : g_chan
      logic [1:0][SAMPLE_W-1:0] chSmp_r;
      always_ff @(posedge clk)
      begin
         if (rst)
         begin
            chSmp_r <= '0;
         end
         else if (link.frameStart || inFrame_r)
         begin
            case (fmt)
               FMT_4211:
               begin
                  chSmp_r[0] <= {lanes[ch][0], lanes[ch][1]};
               end
               FMT_4222:
               begin
                  if (idx[0])
                  begin
                     chSmp_r[0][7:0] <= lanes[ch][0];
                     chSmp_r[1][7:0] <= lanes[ch][1];
                  end
                  else
                  begin
                     chSmp_r[0][15:8] <= lanes[ch][0];
                     chSmp_r[1][15:8] <= lanes[ch][1];
                  end
               end
               FMT_2221:
               begin
                  if (idx[0]) chSmp_r[0][7:0] <= lanes[ch][1];
                  else chSmp_r[0][15:8] <= lanes[ch][1];
               end
               FMT_2242:
               begin
                  case (idx)
                     2'h0: chSmp_r[0][15:8] <= lanes[ch][1];
                     2'h1: chSmp_r[0][7:0] <= lanes[ch][1];
                     2'h2: chSmp_r[1][15:8] <= lanes[ch][1];
                     default: chSmp_r[1][7:0] <= lanes[ch][1];
                  endcase
               end
               default: chSmp_r <= chSmp_r;
            endcase
         end
      end
      assign smp_r[ch] = chSmp_r;
   end

   assign sampleOutValid = valid_r;
   assign samplesPerFrame = (fmt == FMT_4222 || fmt == FMT_2242) ? 2'h2 : 2'h1;
   assign chanAOut0 = smp_r[0][0];
   assign chanAOut1 = smp_r[0][1];
   assign chanBOut0 = smp_r[1][0];
   assign chanBOut1 = smp_r[1][1];

endmodule : lane_deframer

//--- testbench/lane_link_chk.sv
// Concurrent checks on the lane link between the converter end and the receiver end.
`timescale 1ns/100ps
module lane_link_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic [lane_map_pkg::SEL_A_W-1:0] frameFormatSelectA,
   input wire logic frameFormatSelectB,
   input wire logic frameFormatSelectC,
   input wire logic [lane_map_pkg::DECIM_W-1:0] decimation,
   input wire logic [lane_map_pkg::LANES_PER_CHAN-1:0][lane_map_pkg::OCTET_W-1:0] chanALane,
   input wire logic [lane_map_pkg::LANES_PER_CHAN-1:0][lane_map_pkg::OCTET_W-1:0] chanBLane,
   input wire logic [lane_map_pkg::LANES_PER_CHAN-1:0] chanALaneValid,
   input wire logic [lane_map_pkg::LANES_PER_CHAN-1:0] chanBLaneValid,
   input wire logic frameStart,
   input wire logic [5:0] pllMult,
   input wire logic configOk
);
   import lane_map_pkg::*;
   // --------------------------------------------------------------
   // Format decode
   // --------------------------------------------------------------
   // Selects are only changed between frames, so the live value names the format in flight.
   logic [3:0] sel;
   assign sel = {frameFormatSelectA, frameFormatSelectB, frameFormatSelectC};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_low_pair;
      chanALaneValid == 4'h3 [*2];
   endsequence
   sequence s_lane_one_two;
      chanALaneValid == 4'h2 [*2];
   endsequence
   sequence s_lane_one_four;
      chanALaneValid == 4'h2 [*4];
   endsequence
   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   a_pll_twenty: assert property ((sel == 4'h6 || sel == 4'h4) |-> pllMult == 6'h14)
      else $error("four-lane format without the 20x multiplier");
   a_pll_forty: assert property ((sel == 4'h1 || sel == 4'h8) |-> pllMult == 6'h28)
      else $error("two-lane format without the 40x multiplier");
   a_decim_legal: assert property (configOk |-> decimation inside {6'h08, 6'h09, 6'h0a, 6'h0c, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20})
      else $error("legal config with an unknown decimation factor");
   a_decim_four_lane: assert property ((configOk && (sel == 4'h6 || sel == 4'h4)) |-> !(decimation inside {6'h18, 6'h20}))
      else $error("four-lane format accepted with decimation 24 or 32");
   a_upper_lanes_idle: assert property ({chanALaneValid[3:2], chanBLaneValid[3:2]} == 4'h0 && {chanALane[3:2], chanBLane[3:2]} == 32'h0)
      else $error("upper lanes carry data");
   a_chan_mirror: assert property (chanALaneValid == chanBLaneValid)
      else $error("channel lane patterns differ");
   a_one_octet: assert property ((frameStart && sel == 4'h6) |-> chanALaneValid == 4'h3 && $past(configOk))
      else $error("one-octet frame not on both low lanes");
   a_two_octet: assert property ((frameStart && sel == 4'h4) |-> s_low_pair)
      else $error("two-octet four-lane frame has a wrong lane pattern");
   a_lane_one_pair: assert property ((frameStart && sel == 4'h1) |-> s_lane_one_two)
      else $error("two-lane one-sample frame not on lane one for two octets");
   a_lane_one_quad: assert property ((frameStart && sel == 4'h8) |-> s_lane_one_four)
      else $error("two-lane two-sample frame not on lane one for four octets");
endmodule : lane_link_chk

//--- testbench/jesd_real_ddc_lane_mapper_bench.sv
// Self-checking bench joining the framer and deframer across the lane link.
`timescale 1ns/100ps
module jesd_real_ddc_lane_mapper_bench;
   import lane_map_pkg::*;
   logic clk, rst, sampleValid, sampleReady, cfgWrite, cfgSelB, cfgSelC, cfgRejected, configRefused, sampleOutValid;
   logic [1:0] cfgSelA, ddcPerChannel, samplesPerFrame;
   logic [5:0] cfgDecimation, curDec;
   logic [15:0] aS0, aS1, bS0, bS1, aO0, aO1, bO0, bO1;
   logic [3:0] selOf [4] = '{4'h6, 4'h4, 4'h1, 4'h8};
   logic [5:0] decims [9] = '{6'h08, 6'h09, 6'h0a, 6'h0c, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20};
   int n_errors = 0, n_checks = 0, seed = 32'h09a15b49, curFmt = 0;
   lane_link_if link();
   lane_framer lane_framer_inst (.clk(clk), .rst(rst), .link(link.converter), .sampleValid(sampleValid),
      .sampleReady(sampleReady), .chanASample0(aS0), .chanASample1(aS1), .chanBSample0(bS0), .chanBSample1(bS1),
      .ddcPerChannel(ddcPerChannel), .configRefused(configRefused));
   lane_deframer lane_deframer_inst (.clk(clk), .rst(rst), .link(link.receiver), .cfgWrite(cfgWrite),
      .cfgSelA(cfgSelA), .cfgSelB(cfgSelB), .cfgSelC(cfgSelC), .cfgDecimation(cfgDecimation),
      .cfgRejected(cfgRejected), .sampleOutValid(sampleOutValid), .samplesPerFrame(samplesPerFrame),
      .chanAOut0(aO0), .chanAOut1(aO1), .chanBOut0(bO0), .chanBOut1(bO1));
   lane_link_chk lane_link_chk_inst (.clk(clk), .rst(rst), .frameFormatSelectA(link.frameFormatSelectA),
      .frameFormatSelectB(link.frameFormatSelectB), .frameFormatSelectC(link.frameFormatSelectC),
      .decimation(link.decimation), .chanALane(link.chanALane), .chanBLane(link.chanBLane),
      .chanALaneValid(link.chanALaneValid), .chanBLaneValid(link.chanBLaneValid),
      .frameStart(link.frameStart), .pllMult(link.pllMult), .configOk(link.configOk));
   // --------------------------------------------------------------
   // Clock, tasks and expectations
   // --------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Octets expected on lanes 3..0 of one channel at octet k of a frame.
   function automatic logic [31:0] lanesExp(input int f, input int k, input logic [15:0] s0, input logic [15:0] s1);
      logic [15:0] w1;
      logic [7:0] l0, l1;
      w1 = (f == 2 || (f == 3 && k < 2)) ? s0 : s1;
      l0 = (k % 2 == 0) ? s0[15:8] : s0[7:0];
      l1 = (k % 2 == 0) ? w1[15:8] : w1[7:0];
      if (f == 0)
         return {16'h0, s0[7:0], s0[15:8]};
      return {16'h0, l1, (f == 1) ? l0 : 8'h00};
   endfunction : lanesExp
   task automatic cfg(input logic [3:0] s, input logic [5:0] d, input logic rej, input int f);
      {cfgSelA, cfgSelB, cfgSelC} = s;
      cfgDecimation = d;
      cfgWrite = 1'b1;
      tick();
      cfgWrite = 1'b0;
      chk(32'(cfgRejected), 32'(rej));
      if (!rej)
      begin
         curFmt = f;
         curDec = d;
      end
      chk(32'(link.pllMult), (curFmt < 2) ? 32'h14 : 32'h28);
      chk(32'(link.decimation), 32'(curDec));
      chk(32'({configRefused, link.frameFormatSelectA, link.frameFormatSelectB, link.frameFormatSelectC}),
         32'(selOf[curFmt]));
      tick();
   endtask : cfg
   task automatic frame(input int f, input logic [15:0] a0, input logic [15:0] a1, input logic [15:0] b0,
                        input logic [15:0] b1);
      int len, k, w;
      len = (f == 0) ? 1 : (f == 3) ? 4 : 2;
      w = 0;
      while (sampleReady !== 1'b1)
      begin
         tick();
         w++;
         if (w > 20)
         begin
            n_errors++;
            $display("ready never came at %0t", $time);
            summarize();
         end
      end
      {aS0, aS1, bS0, bS1} = {a0, a1, b0, b1};
      sampleValid = 1'b1;
      tick();
      sampleValid = 1'b0;
      for (k = 0; k < len; k++)
      begin
         chk(32'(link.frameStart), 32'(k == 0));
         chk(32'(link.chanALaneValid), (f < 2) ? 32'h3 : 32'h2);
         chk(link.chanALane, lanesExp(f, k, a0, a1));
         chk(link.chanBLane, lanesExp(f, k, b0, b1));
         chk(32'(sampleReady), 32'(k == len - 1));
         tick();
      end
      chk(32'({sampleOutValid, samplesPerFrame}), (f % 2 == 1) ? 32'h6 : 32'h5);
      chk({aO0, bO0}, {a0, b0});
      if (f % 2 == 1)
         chk({aO1, bO1}, {a1, b1});
   endtask : frame
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial
   begin
      int f, i;
      rst = 1'b1;
      {sampleValid, cfgWrite, cfgSelA, cfgSelB, cfgSelC, cfgDecimation} = '0;
      {aS0, aS1, bS0, bS1} = '0;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      chk(32'({ddcPerChannel, link.pllMult}), 32'h54);
      for (f = 0; f < 4; f++)
         for (i = 0; i < 9; i++)
            cfg(selOf[f], decims[i], f < 2 && i > 6, f);
      $display("test decimation sweep done");
      cfg(4'hf, 6'h08, 1'b1, 0);
      cfg(selOf[3], 6'h07, 1'b1, 0);
      cfg(selOf[1], 6'h20, 1'b1, 0);
      frame(3, 16'hffff, 16'h0000, 16'h8001, 16'h7ffe);
      $display("test rejected config done");
      for (f = 0; f < 4; f++)
      begin
         cfg(selOf[f], 6'h08, 1'b0, f);
         frame(f, 16'h8001, 16'h7ffe, 16'hffff, 16'h0000);
      end
      $display("test corner samples done");
      for (i = 0; i < 24; i++)
      begin
         f = $unsigned($random(seed)) % 4;
         cfg(selOf[f], decims[$unsigned($random(seed)) % ((f < 2) ? 7 : 9)], 1'b0, f);
         repeat (2) frame(f, 16'($random(seed)), 16'($random(seed)), 16'($random(seed)), 16'($random(seed)));
      end
      $display("test random frames done");
      rst = 1'b1;
      repeat (2) tick();
      rst = 1'b0;
      curFmt = 0;
      curDec = DECIM_RESET;
      chk(32'({link.decimation, link.pllMult}), 32'h214);
      chk(32'({link.frameFormatSelectA, link.frameFormatSelectB, link.frameFormatSelectC}), 32'h6);
      chk(32'({sampleOutValid, link.frameStart, link.chanALaneValid, sampleReady}), 32'h1);
      frame(0, 16'h00ff, 16'hff00, 16'hff00, 16'h00ff);
      $display("test reset in run done");
      summarize();
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      n_errors++;
      $display("run limit reached at %0t", $time);
      summarize();
   end
endmodule : jesd_real_ddc_lane_mapper_bench
